// File: bench/bandgap_reference_control_sva.sv
// Assertions for the band gap reference control bank
`timescale 1ns/1ps
module bandgap_reference_control_sva #(
    parameter int ADDR_W = 4
) (
    // Clock, reset and register port
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    // Power state and analog controls
    input wire logic i_idle,
    input wire logic i_sleep,
    input wire logic [2:0] o_bandgap_enable,
    input wire logic [2:0] o_buffer_enable,
    input wire logic [2:0] o_standby,
    input wire logic [2:0] o_pin_drive,
    input wire logic [5:0] o_level
);
    // One clock domain, so clock and reset are stated once
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    AST_PIN0: assert property (o_pin_drive[0] == 1'b0) else $error("pin drive on channel 0");
    AST_RD_GAP: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data outside slot");
    AST_RD_MASK: assert property ($past(i_rd) |-> (o_rdata & 16'h4f3c) == 16'h0000) else $error("unused bit set");
    AST_RD_CH0: assert property ($past(i_rd && i_addr == '0) |-> !o_rdata[7]) else $error("channel 0 pin bit");
    AST_BUF: assert property ((o_buffer_enable & ~o_bandgap_enable) == 3'h0) else $error("buffer without gap");
    AST_STBY: assert property ((o_standby & ~o_buffer_enable) == 3'h0) else $error("standby while off");
    AST_PIN: assert property ((o_pin_drive & ~o_buffer_enable) == 3'h0) else $error("pin while off");
    AST_WR_EN: assert property (i_wr && i_addr == 1 ##1 !i_sleep |=>
        o_bandgap_enable[1] == $past(i_wdata[15], 2)) else $error("enable not following write");
    AST_LEVEL: assert property (i_wr && i_addr == 2 |-> ##2 o_level[5:4] == $past(i_wdata[1:0], 2))
        else $error("level not following write");
    // Main scenarios
    COV_PIN: cover property (o_pin_drive[2]);
    COV_STBY: cover property (o_standby[1]);
    COV_IDLE: cover property (i_idle && o_bandgap_enable[0] && !o_buffer_enable[0]);
endmodule : bandgap_reference_control_sva

bind bandgap_reference_control bandgap_reference_control_sva #(.ADDR_W(ADDR_W)) u_sva (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_idle(i_idle), .i_sleep(i_sleep),
    .o_bandgap_enable(o_bandgap_enable), .o_buffer_enable(o_buffer_enable), .o_standby(o_standby),
    .o_pin_drive(o_pin_drive), .o_level(o_level));

// File: bench/bandgap_reference_control_tb.sv
// Self-checking bench for the band gap reference control bank
`timescale 1ns/1ps
module bandgap_reference_control_tb;
    logic i_sys_clk, i_rst_n, i_wr, i_rd, i_idle, i_sleep;
    logic [3:0] i_addr;
    logic [15:0] i_wdata, o_rdata;
    logic [2:0] o_bandgap_enable, o_buffer_enable, o_standby, o_pin_drive;
    logic [5:0] o_level;
    logic [15:0] sh [3];
    int bad_count, samples_checked;
    bandgap_reference_control dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_idle(i_idle),
        .i_sleep(i_sleep), .o_bandgap_enable(o_bandgap_enable), .o_buffer_enable(o_buffer_enable),
        .o_standby(o_standby), .o_pin_drive(o_pin_drive), .o_level(o_level));
    // 10 MHz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 chk({2'b00, o_rdata}, {2'b00, exp});
    endtask : rd
    // Expected analog controls from the shadow words; idle and sleep are never high together
    function automatic logic [17:0] model(input logic id, input logic sl);
        logic [2:0] bg, bf;
        for (int k = 0; k < 3; k++) begin
            bg[k] = sh[k][15] & ~(sl & ~sh[k][12]);
            bf[k] = bg[k] & ~(id & sh[k][13]);
        end
        return {bg, bf, bf & {sh[2][6], sh[1][6], sh[0][6]}, bf & {sh[2][7], sh[1][7], 1'b0},
            sh[2][1:0], sh[1][1:0], sh[0][1:0]};
    endfunction : model
    task automatic step(input logic [15:0] w0, w1, w2, input logic id, sl);
        @(posedge i_sys_clk);
        i_idle <= id;
        i_sleep <= sl;
        wr(4'h0, w0);
        wr(4'h1, w1);
        wr(4'h2, w2);
        sh[0] = w0 & 16'hb043;
        sh[1] = w1 & 16'hb0c3;
        sh[2] = w2 & 16'hb0c3;
        repeat (2) @(posedge i_sys_clk);
        #1 chk({o_bandgap_enable, o_buffer_enable, o_standby, o_pin_drive, o_level}, model(id, sl));
    endtask : step
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    // Main sequence
    initial begin
        {i_rst_n, i_wr, i_rd, i_idle, i_sleep, i_addr, i_wdata} = '0;
        sh = '{default: 16'h0000};
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        #1 chk({o_bandgap_enable, o_buffer_enable, o_standby, o_pin_drive, o_level}, 18'h0);
        for (int k = 0; k < 3; k++) rd(k[3:0], 16'h0000);
        step(16'hffff, 16'hffff, 16'hffff, 1'b0, 1'b0);
        wr(4'h3, 16'hffff);
        for (int k = 0; k < 4; k++) rd(k[3:0], k < 3 ? sh[k] : 16'h0000);
        step(16'ha001, 16'h9082, 16'h0043, 1'b0, 1'b0);
        step(16'ha001, 16'h9082, 16'h0043, 1'b1, 1'b0);
        step(16'ha001, 16'h9082, 16'h0043, 1'b0, 1'b1);
        step(16'h8000, 16'h80c0, 16'ha0c2, 1'b1, 1'b0);
        // Mid-run reset must clear every control word and analog output
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1 chk({o_bandgap_enable, o_buffer_enable, o_standby, o_pin_drive, o_level}, 18'h0);
        @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        sh = '{default: 16'h0000};
        for (int k = 0; k < 3; k++) rd(k[3:0], 16'h0000);
        step(16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
        print_verdict();
    end
endmodule : bandgap_reference_control_tb

// File: hdl/bandgap_reference_control.sv
// Control register bank for the three band gap reference channels
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "bandgap_reference_defines.svh"
module bandgap_reference_control
    import bandgap_reference_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Device power state, same clock domain
    input wire logic i_idle,
    input wire logic i_sleep,
    // Analog controls, one bit per channel except o_level, which has two bits per channel
    output logic [2:0] o_bandgap_enable,
    output logic [2:0] o_buffer_enable,
    output logic [2:0] o_standby,
    output logic [2:0] o_pin_drive,
    output logic [5:0] o_level
);
    // Offsets are 4-bit; a narrower port could not reach them
    if (ADDR_W < 4) begin : g_addr_w_check
        $error("ADDR_W must be at least 4");
    end

    ref_ctrl_t ctrl_ff [3];
    ref_ctrl_t nxt_ctrl [3];
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    power_state_t pwr_state;

    // Mask of bits that exist in a channel's register
    function automatic ref_ctrl_t chan_mask(input int ch);
        chan_mask = (ch == 0) ? `REF_MASK_INTERNAL : `REF_MASK_BUFFERED;
    endfunction : chan_mask

    // Register index for an address, 3 when unmapped
    function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
        decode = 2'h3;
        if (a == ADDR_W'(`REF_CTRL0_OFFSET)) begin
            decode = 2'h0;
        end else if (a == ADDR_W'(`REF_CTRL1_OFFSET)) begin
            decode = 2'h1;
        end else if (a == ADDR_W'(`REF_CTRL2_OFFSET)) begin
            decode = 2'h2;
        end
    endfunction : decode

    // Sleep outranks Idle when both are reported
    always_comb begin
        if (i_sleep) begin
            pwr_state = PWR_SLEEP;
        end else if (i_idle) begin
            pwr_state = PWR_IDLE;
        end else begin
            pwr_state = PWR_RUN;
        end
    end

    // Writes land in one channel only; unused bits are dropped
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_ctrl[i] = ctrl_ff[i];
            if (i_wr && decode(i_addr) == 2'(i)) begin
                nxt_ctrl[i] = i_wdata & chan_mask(i);
            end
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads give zero
    always_comb begin
        nxt_rdata = 16'h0000;
        if (i_rd) begin
            case (decode(i_addr))
                2'h0: nxt_rdata = ctrl_ff[0];
                2'h1: nxt_rdata = ctrl_ff[1];
                2'h2: nxt_rdata = ctrl_ff[2];
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    // Control words; reset leaves every channel powered down
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 3; i++) begin
                ctrl_ff[i] <= `REF_CTRL_RESET;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                ctrl_ff[i] <= nxt_ctrl[i];
            end
        end
    end

    // Read data register; it falls back to zero once the read slot is over
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata = rdata_ff;

    // One gate per channel; only channels 1 and 2 own a pin
    for (genvar g = 0; g < 3; g++) begin : g_chan
        ref_channel_gate #(
            .HAS_PIN(g != 0)
        ) u_gate (
            .i_sys_clk(i_sys_clk),
            .i_rst_n(i_rst_n),
            .i_ctrl(ctrl_ff[g]),
            .i_pwr_state(pwr_state),
            .o_bandgap_enable(o_bandgap_enable[g]),
            .o_buffer_enable(o_buffer_enable[g]),
            .o_standby(o_standby[g]),
            .o_pin_drive(o_pin_drive[g]),
            .o_level(o_level[2*g+1:2*g])
        );
    end
endmodule : bandgap_reference_control

// File: hdl/bandgap_reference_defines.svh
// Register offsets, field positions, reset values and rule summary for the band gap reference bank
// How it works
// - Each of the three reference channels has its own control register and is gated on its own.
// - Channel 0 feeds only the on-chip analog consumers and has no pin output enable bit.
// - Bit 15 set enables the channel's band gap and buffer; clear powers both down.
// - Bit 13 set turns the buffer off while the device is in Idle; clear keeps it running through Idle.
// - On channels 1 and 2, bit 7 set routes the buffered reference to the pin; clear leaves the pin undriven.
// - Bit 6 set places the buffer in low-power standby; clear lets it work normally.
// - Unused bits ignore writes and read back as zero.
`ifndef BANDGAP_REFERENCE_DEFINES_SVH
`define BANDGAP_REFERENCE_DEFINES_SVH

// Register offsets on the plain register port
`define REF_CTRL0_OFFSET 4'h0
`define REF_CTRL1_OFFSET 4'h1
`define REF_CTRL2_OFFSET 4'h2

// Field positions
`define REF_ENABLE_BIT 15
`define REF_IDLE_STOP_BIT 13
`define REF_SLEEP_RUN_BIT 12
`define REF_PIN_DRIVE_BIT 7
`define REF_STANDBY_BIT 6
`define REF_LEVEL_LSB 0
`define REF_LEVEL_MSB 1

// Implemented bit masks
`define REF_MASK_INTERNAL 16'hb043
`define REF_MASK_BUFFERED 16'hb0c3

// Reset value of every control register
`define REF_CTRL_RESET 16'h0000

`endif

// File: hdl/bandgap_reference_pkg.sv
// Types shared by the band gap reference bank
package bandgap_reference_pkg;
    typedef logic [15:0] ref_ctrl_t;
    typedef logic [1:0] ref_level_t;
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_IDLE,
        PWR_SLEEP
    } power_state_t;
endpackage : bandgap_reference_pkg

// File: hdl/ref_channel_gate.sv
// One reference channel: decodes its control word against the device power state
`timescale 1ns/1ps
`include "bandgap_reference_defines.svh"
module ref_channel_gate
    import bandgap_reference_pkg::*;
#(
    parameter bit HAS_PIN = 1'b1
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Control and power state
    input wire ref_ctrl_t i_ctrl,
    input wire power_state_t i_pwr_state,
    // Analog controls
    output logic o_bandgap_enable,
    output logic o_buffer_enable,
    output logic o_standby,
    output logic o_pin_drive,
    output ref_level_t o_level
);
    logic bandgap_en_ff;
    logic buffer_en_ff;
    logic standby_ff;
    logic pin_ff;
    ref_level_t level_ff;
    logic nxt_bandgap_en;
    logic nxt_buffer_en;
    logic nxt_standby;
    logic nxt_pin;
    ref_level_t nxt_level;

    // Combine control bits with Idle and Sleep
    always_comb begin
        logic sleep_off;
        logic idle_off;
        sleep_off = 1'b0;
        idle_off = 1'b0;
        sleep_off = (i_pwr_state == PWR_SLEEP) && !i_ctrl[`REF_SLEEP_RUN_BIT];
        idle_off = (i_pwr_state == PWR_IDLE) && i_ctrl[`REF_IDLE_STOP_BIT];
        nxt_bandgap_en = i_ctrl[`REF_ENABLE_BIT] && !sleep_off;
        nxt_buffer_en = nxt_bandgap_en && !idle_off;
        nxt_standby = nxt_buffer_en && i_ctrl[`REF_STANDBY_BIT];
        // Pin only carries a live buffer; channel 0 never drives one
        nxt_pin = HAS_PIN && nxt_buffer_en && i_ctrl[`REF_PIN_DRIVE_BIT];
        nxt_level = i_ctrl[`REF_LEVEL_MSB:`REF_LEVEL_LSB];
    end

    // Register the analog controls so they never glitch
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bandgap_en_ff <= 1'b0;
            buffer_en_ff <= 1'b0;
            standby_ff <= 1'b0;
            pin_ff <= 1'b0;
            level_ff <= 2'h0;
        end else begin
            bandgap_en_ff <= nxt_bandgap_en;
            buffer_en_ff <= nxt_buffer_en;
            standby_ff <= nxt_standby;
            pin_ff <= nxt_pin;
            level_ff <= nxt_level;
        end
    end

    assign o_bandgap_enable = bandgap_en_ff;
    assign o_buffer_enable = buffer_en_ff;
    assign o_standby = standby_ff;
    assign o_pin_drive = pin_ff;
    assign o_level = level_ff;
endmodule : ref_channel_gate
